// *** rtl/ddr_burst2_sram_port.sv ***
// device side logic of the burst-of-two double data rate memory port
`default_nettype none
module ddr_burst2_sram_port #(
  parameter logic [11:0] LOCK_KCYC = sram_port_pkg::LOCK_KCYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic load_strobe_n,
  input wire logic read_write_sel,
  input wire sram_port_pkg::addr_t address_inputs,
  input wire sram_port_pkg::word_t bidir_data_lines_in,
  input wire sram_port_pkg::bmask_t byte_write_n,
  input wire logic dll_off_n,
  input wire logic narrow_mode,
  output sram_port_pkg::word_t read_data_outputs,
  output sram_port_pkg::word_t bidir_data_lines_oe_n,
  output logic echo_clock_true,
  output logic echo_clock_comp,
  output logic output_valid_flag,
  output logic dll_locked
);
  import sram_port_pkg::*;

  // ==========================================
  // input synchronisers
  logic [IN_W-1:0] in_bus;
  logic [IN_W-1:0] s1_r;
  logic [IN_W-1:0] s1_nxt;
  logic [IN_W-1:0] s2_r;
  logic [IN_W-1:0] s2_nxt;
  logic k_s;
  logic kn_s;
  logic ld_n_s;
  logic rw_s;
  logic dll_on_s;
  logic narrow_s;
  addr_t addr_s;
  word_t din_s;
  bmask_t bw_s;

  assign in_bus = {k_clk, k_clk_n, load_strobe_n, read_write_sel, address_inputs,
                   bidir_data_lines_in, byte_write_n, dll_off_n, narrow_mode};
  assign {k_s, kn_s, ld_n_s, rw_s, addr_s, din_s, bw_s, dll_on_s, narrow_s} = s2_r;

  always_comb
  begin
    s1_nxt = in_bus;
    s2_nxt = s1_r;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end
    else
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  // ==========================================
  // input clock edge detection
  logic k_prev_r;
  logic k_prev_nxt;
  logic kn_prev_r;
  logic kn_prev_nxt;
  logic k_rise;
  logic kn_rise;

  assign k_rise = k_s & ~k_prev_r;
  assign kn_rise = kn_s & ~kn_prev_r;

  always_comb
  begin
    k_prev_nxt = k_s;
    kn_prev_nxt = kn_s;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      k_prev_r <= 1'b0;
      kn_prev_r <= 1'b0;
    end
    else
    begin
      k_prev_r <= k_prev_nxt;
      kn_prev_r <= kn_prev_nxt;
    end
  end

  // ==========================================
  // command capture and read pipeline
  logic [PIPE_D-1:0] pv_r;
  logic [PIPE_D-1:0] pv_nxt;
  addr_t pa_r [PIPE_D];
  addr_t pa_nxt [PIPE_D];
  logic wp_r;
  logic wp_nxt;
  addr_t wa_r;
  addr_t wa_nxt;

  always_comb
  begin
    pv_nxt = pv_r;
    pa_nxt = pa_r;
    wp_nxt = wp_r;
    wa_nxt = wa_r;
    if (k_rise) // R01
    begin
      for (int i = PIPE_D - 1; i > 0; i--)
      begin
        pv_nxt[i] = pv_r[i-1];
        pa_nxt[i] = pa_r[i-1];
      end
      pv_nxt[0] = ~ld_n_s & rw_s; // R12
      wp_nxt = ~ld_n_s & ~rw_s; // R12
      if (!ld_n_s) // R09
      begin
        if (rw_s)
        begin
          pa_nxt[0] = addr_s; // R14
        end
        else
        begin
          wa_nxt = addr_s; // R14
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pv_r <= '0;
      for (int i = 0; i < PIPE_D; i++)
      begin
        pa_r[i] <= ADDR_ZERO;
      end
      wp_r <= 1'b0;
      wa_r <= ADDR_ZERO;
    end
    else
    begin
      pv_r <= pv_nxt;
      pa_r <= pa_nxt;
      wp_r <= wp_nxt;
      wa_r <= wa_nxt;
    end
  end

  // ==========================================
  // write beats and storage
  word_t mem0_r [MEM_D];
  word_t mem0_nxt [MEM_D];
  word_t mem1_r [MEM_D];
  word_t mem1_nxt [MEM_D];
  logic wb1_r;
  logic wb1_nxt;
  addr_t wd_a_r;
  addr_t wd_a_nxt;

  always_comb
  begin
    mem0_nxt = mem0_r;
    mem1_nxt = mem1_r;
    wb1_nxt = wb1_r;
    wd_a_nxt = wd_a_r;
    if (kn_rise && wb1_r) // R16
    begin
      mem1_nxt[mem_idx(wd_a_r)] = merge(mem1_r[mem_idx(wd_a_r)], din_s, bw_s, narrow_s); // R15
      wb1_nxt = 1'b0;
    end
    if (k_rise && wp_r) // R17
    begin
      mem0_nxt[mem_idx(wa_r)] = merge(mem0_r[mem_idx(wa_r)], din_s, bw_s, narrow_s); // R15
      wd_a_nxt = wa_r;
      wb1_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < MEM_D; i++)
      begin
        mem0_r[i] <= WORD_ZERO;
        mem1_r[i] <= WORD_ZERO;
      end
      wb1_r <= 1'b0;
      wd_a_r <= ADDR_ZERO;
    end
    else
    begin
      mem0_r <= mem0_nxt;
      mem1_r <= mem1_nxt;
      wb1_r <= wb1_nxt;
      wd_a_r <= wd_a_nxt;
    end
  end

  // ==========================================
  // read data, valid flag and echo clocks
  word_t dout_r;
  word_t dout_nxt;
  word_t oe_n_r;
  word_t oe_n_nxt;
  logic vld_r;
  logic vld_nxt;
  logic eck_r;
  logic eck_nxt;
  logic eckn_r;
  logic eckn_nxt;
  logic drv;
  word_t rdata;

  always_comb
  begin
    drv = 1'b0;
    rdata = WORD_ZERO;
    if (kn_rise)
    begin
      if (dll_on_s && pv_r[STG_ON]) // R13
      begin
        drv = 1'b1;
        rdata = mem0_r[mem_idx(pa_r[STG_ON])];
      end
      else if (!dll_on_s && pv_r[STG_OFF_B1]) // R07
      begin
        drv = 1'b1;
        rdata = mem1_r[mem_idx(pa_r[STG_OFF_B1])];
      end
    end
    else if (k_rise)
    begin
      if (dll_on_s && pv_r[STG_ON]) // R13
      begin
        drv = 1'b1;
        rdata = mem1_r[mem_idx(pa_r[STG_ON])];
      end
      else if (!dll_on_s && pv_r[STG_OFF_B0]) // R07
      begin
        drv = 1'b1;
        rdata = mem0_r[mem_idx(pa_r[STG_OFF_B0])];
      end
    end
  end

  always_comb
  begin
    dout_nxt = dout_r;
    oe_n_nxt = oe_n_r;
    vld_nxt = vld_r;
    eck_nxt = k_s; // R03
    eckn_nxt = kn_s; // R03
    if (k_rise || kn_rise) // R04
    begin
      vld_nxt = drv; // R08
      dout_nxt = drv ? (rdata & lane_mask(narrow_s)) : WORD_ZERO; // R11
      oe_n_nxt = drv ? ~lane_mask(narrow_s) : OE_OFF; // R10
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dout_r <= WORD_ZERO;
      oe_n_r <= OE_OFF;
      vld_r <= 1'b0;
      eck_r <= 1'b0;
      eckn_r <= 1'b0;
    end
    else
    begin
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
      vld_r <= vld_nxt;
      eck_r <= eck_nxt;
      eckn_r <= eckn_nxt;
    end
  end

  assign read_data_outputs = dout_r;
  assign bidir_data_lines_oe_n = oe_n_r;
  assign output_valid_flag = vld_r;
  assign echo_clock_true = eck_r;
  assign echo_clock_comp = eckn_r;

  // ==========================================
  // delay-locked loop lock tracking
  logic [LOCK_CNT_W-1:0] lock_cnt_r;
  logic [LOCK_CNT_W-1:0] lock_cnt_nxt;
  logic locked_r;
  logic locked_nxt;

  always_comb
  begin
    lock_cnt_nxt = lock_cnt_r;
    locked_nxt = locked_r;
    if (!dll_on_s) // R05
    begin
      lock_cnt_nxt = '0;
      locked_nxt = 1'b0;
    end
    else if (k_rise && !locked_r) // R06
    begin
      lock_cnt_nxt = lock_cnt_r + LOCK_CNT_ONE;
      if (lock_cnt_nxt >= LOCK_KCYC)
      begin
        locked_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
    end
    else
    begin
      lock_cnt_r <= lock_cnt_nxt;
      locked_r <= locked_nxt;
    end
  end

  assign dll_locked = locked_r;

endmodule
`default_nettype wire

// *** rtl/sram_port_pkg.sv ***
// constants, types and helpers shared by the burst-of-two memory port
// Operation
// R01 - address/control on k rise, data both clocks
// R02 - controller keeps clocks opposite, never resting
// R03 - echo clocks toggle always, even when idle
// R04 - echo edges match data output updates
// R05 - dll off low: bypass, clear lock
// R06 - dll running: lock after lock time
// R07 - dll off: read latency 1.0 cycle
// R08 - valid flag marks read data, echo aligned
// R09 - address ignored while deselected
// R10 - data pins released when no read
// R11 - narrow uses 18 lines, wide 36
// R12 - select high reads, low writes
// R13 - read beats at 2.5 and 3 cycles
// R14 - load registers address; nop keeps read
// R15 - byte write enables lane, per beat
// R16 - every access is two beats
// R17 - write beats one cycle after command
`default_nettype none
package sram_port_pkg;
  // ==========================================
  // widths
  localparam int DATA_W = 36;
  localparam int NARROW_W = 18;
  localparam int BYTE_W = 9;
  localparam int BYTES = 4;
  localparam int NARROW_BYTES = 2;
  localparam int ADDR_W = 18;
  localparam int MEM_AW = 4;
  localparam int MEM_D = 16;
  localparam int PIPE_D = 3;
  localparam int IN_W = ADDR_W + DATA_W + BYTES + 6;
  // ==========================================
  // read pipeline stages per latency mode
  localparam int STG_ON = 2;
  localparam int STG_OFF_B0 = 0;
  localparam int STG_OFF_B1 = 1;
  // ==========================================
  // dll lock counting, in k cycles
  localparam int LOCK_CNT_W = 12;
  localparam logic [LOCK_CNT_W-1:0] LOCK_KCYC_DEF = 12'h400;
  localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_ONE = 12'h001;
  // ==========================================
  // types and reset values
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [BYTES-1:0] bmask_t;
  typedef logic [MEM_AW-1:0] idx_t;
  localparam word_t WORD_ZERO = 36'h0_0000_0000;
  localparam word_t OE_OFF = 36'hf_ffff_ffff;
  localparam addr_t ADDR_ZERO = 18'h0_0000;
  localparam logic [IN_W-1:0] SYNC_RST = 64'h0000_0000_0000_0000;
  // ==========================================
  // helpers
  function automatic idx_t mem_idx(input addr_t a);
    mem_idx = a[MEM_AW-1:0];
  endfunction
  function automatic word_t lane_mask(input logic narrow);
    lane_mask = narrow ? {{(DATA_W-NARROW_W){1'b0}}, {NARROW_W{1'b1}}} : OE_OFF;
  endfunction
  function automatic word_t merge(input word_t old, input word_t din,
                                  input bmask_t bw_n, input logic narrow);
    merge = old;
    for (int b = 0; b < BYTES; b++)
    begin
      if (!bw_n[b] && (!narrow || b < NARROW_BYTES))
      begin
        merge[b*BYTE_W +: BYTE_W] = din[b*BYTE_W +: BYTE_W];
      end
    end
  endfunction
endpackage
`default_nettype wire

// *** tb/sram_port_properties.sv ***
// assertions on the memory port pins
`default_nettype none
module sram_port_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic k_clk,
  input wire logic dll_off_n,
  input wire logic narrow_mode,
  input wire sram_port_pkg::word_t read_data_outputs,
  input wire sram_port_pkg::word_t bidir_data_lines_oe_n,
  input wire logic echo_clock_true,
  input wire logic echo_clock_comp,
  input wire logic output_valid_flag,
  input wire logic dll_locked
);
  import sram_port_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ====
  // sequences
  sequence s_echo;
    $changed(echo_clock_true) || $changed(echo_clock_comp);
  endsequence
  sequence s_two_beats;
    output_valid_flag [*8];
  endsequence
  // ====
  // properties
  property p_idle;
    !output_valid_flag |-> &bidir_data_lines_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_drive;
    output_valid_flag |-> bidir_data_lines_oe_n[17:0] == 18'h0_0000;
  endproperty
  a_drive: assert property (p_drive) else $error("valid undriven");
  property p_narrow;
    narrow_mode && $past(narrow_mode, 4) |-> &bidir_data_lines_oe_n[35:18];
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lanes");
  property p_echo;
    $rose(k_clk) |-> ##[2:4] $rose(echo_clock_true);
  endproperty
  a_echo: assert property (p_echo) else $error("echo stopped");
  property p_data_echo;
    $changed(read_data_outputs) |-> s_echo;
  endproperty
  a_data_echo: assert property (p_data_echo) else $error("data off echo");
  property p_first_on;
    $rose(output_valid_flag) && dll_off_n |-> $rose(echo_clock_comp);
  endproperty
  a_first_on: assert property (p_first_on) else $error("beat0 edge");
  property p_first_off;
    $rose(output_valid_flag) && !dll_off_n |-> $rose(echo_clock_true);
  endproperty
  a_first_off: assert property (p_first_off) else $error("bypass edge");
  property p_burst;
    $rose(output_valid_flag) |-> s_two_beats;
  endproperty
  a_burst: assert property (p_burst) else $error("short burst");
  property p_clear;
    !dll_off_n [*4] |-> !dll_locked;
  endproperty
  a_clear: assert property (p_clear) else $error("lock kept");
endmodule
bind ddr_burst2_sram_port sram_port_properties sram_port_properties_i (.core_clk, .rst,
  .k_clk, .dll_off_n, .narrow_mode, .read_data_outputs, .bidir_data_lines_oe_n,
  .echo_clock_true, .echo_clock_comp, .output_valid_flag, .dll_locked);
`default_nettype wire

// *** tb/mem_ctrl_model.sv ***
// controller model: link clocks, commands and write data
`default_nettype none
module mem_ctrl_model (
  input wire sram_port_pkg::word_t read_data_outputs,
  input wire sram_port_pkg::word_t bidir_data_lines_oe_n,
  output var logic k_clk,
  output var logic k_clk_n,
  output var logic load_strobe_n,
  output var logic read_write_sel,
  output var sram_port_pkg::addr_t address_inputs,
  output var sram_port_pkg::word_t bidir_data_lines_in,
  output var sram_port_pkg::bmask_t byte_write_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import sram_port_pkg::*;
  word_t drv = '0;
  word_t d0_a = '0;
  word_t d1_a = '0;
  word_t d1_b = '0;
  bmask_t b0_a = '1;
  bmask_t b1_a = '1;
  bmask_t b1_b = '1;
  logic wr_a = 1'b0;
  logic wr_b = 1'b0;
  time t_cmd;
  assign bidir_data_lines_in = (~bidir_data_lines_oe_n & read_data_outputs)
    | (bidir_data_lines_oe_n & drv);
  initial
  begin
    k_clk = 1'b0;
    k_clk_n = 1'b1;
    load_strobe_n = 1'b1;
    read_write_sel = 1'b0;
    address_inputs = '0;
    byte_write_n = '1;
    #4;
    forever
    begin
      k_clk = ~k_clk;
      k_clk_n = ~k_clk;
      #62.5;
    end
  end
  // ====
  // one k cycle slot; a command is taken at the next k rise,
  // its write beats at the k rise and k_n rise one slot later
  task automatic op(input logic ld_n, input logic rw, input addr_t a, input word_t d0,
                    input word_t d1, input bmask_t b0, input bmask_t b1);
    @(posedge k_clk);
    t_cmd = $time;
    #33;
    load_strobe_n = ld_n;
    read_write_sel = rw;
    address_inputs = a;
    drv = wr_b ? d1_b : ~drv;
    byte_write_n = wr_b ? b1_b : '1;
    wr_b = wr_a;
    d1_b = d1_a;
    b1_b = b1_a;
    #64;
    drv = wr_a ? d0_a : ~drv;
    byte_write_n = wr_a ? b0_a : '1;
    wr_a = !ld_n && !rw;
    d0_a = d0;
    d1_a = d1;
    b0_a = b0;
    b1_a = b1;
  endtask
endmodule
`default_nettype wire

// *** tb/ddr_burst2_sram_port_tb.sv ***
// self-checking bench for the memory port
`default_nettype none
module ddr_burst2_sram_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sram_port_pkg::*;
  typedef struct {addr_t a; word_t base; word_t d0; word_t d1; bmask_t bw;} row_s;
  row_s rows[3] = '{'{18'h0_0001, 36'h1_2345_6789, 36'ha_bcde_f012, 36'h3_4567_89ab, 4'h0},
    '{18'h1_0002, 36'hf_ffff_ffff, 36'h0_0000_0000, 36'h5_5555_5555, 4'h5},
    '{18'h0_000f, 36'h0_0000_0000, 36'hf_ffff_ffff, 36'h0_0f0f_0f0f, 4'ha}};
  logic core_clk, rst, k_clk, k_clk_n, load_strobe_n, read_write_sel, dll_off_n;
  logic narrow_mode, echo_clock_true, echo_clock_comp, output_valid_flag, dll_locked;
  logic pt, pc;
  addr_t address_inputs;
  word_t bidir_data_lines_in, read_data_outputs, bidir_data_lines_oe_n;
  bmask_t byte_write_n;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  word_t beats[$];
  time t_beat;
  ddr_burst2_sram_port #(.LOCK_KCYC(12'h004)) ddr_burst2_sram_port_i (.core_clk, .rst,
    .k_clk, .k_clk_n, .load_strobe_n, .read_write_sel, .address_inputs,
    .bidir_data_lines_in, .byte_write_n, .dll_off_n, .narrow_mode, .read_data_outputs,
    .bidir_data_lines_oe_n, .echo_clock_true, .echo_clock_comp, .output_valid_flag,
    .dll_locked);
  mem_ctrl_model mem_ctrl_model_i (.read_data_outputs, .bidir_data_lines_oe_n, .k_clk,
    .k_clk_n, .load_strobe_n, .read_write_sel, .address_inputs, .bidir_data_lines_in,
    .byte_write_n);
  // ====
  // helpers
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input word_t seen, input word_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic word_t lanes(input word_t o, input word_t n, input bmask_t bw_n);
    for (int b = 0; b < 4; b++)
    begin
      if (!bw_n[b])
      begin
        o[b*9 +: 9] = n[b*9 +: 9];
      end
    end
    return o;
  endfunction
  task automatic rd(input addr_t a, input word_t e0, input word_t e1, input int lat);
    word_t m;
    time tk;
    m = narrow_mode ? 36'h0_0003_ffff : '1;
    beats.delete();
    mem_ctrl_model_i.op(1'b0, 1'b1, a, '0, '0, '1, '1);
    // the command is taken at the k rise after the slot that drives it
    tk = mem_ctrl_model_i.t_cmd + 125;
    repeat (5) mem_ctrl_model_i.op(1'b1, 1'b0, ~a, '1, '1, '0, '0);
    check("beats", 36'(beats.size()), 36'h2);
    beats.push_back('x);
    beats.push_back('x);
    check("beat0", beats[0] & m, e0 & m);
    check("beat1", beats[1] & m, e1 & m);
    check("latency", 36'((t_beat - tk) / 62), 36'(lat));
  endtask
  // ====
  // clock, monitor, timeout
  initial
  begin
    core_clk = 1'b0;
    forever
    begin
      #5 core_clk = ~core_clk;
    end
  end
  always @(negedge core_clk)
  begin
    if (output_valid_flag === 1'b1 && ((echo_clock_true && !pt) || (echo_clock_comp && !pc)))
    begin
      if (beats.size() == 0)
      begin
        t_beat = $time;
      end
      beats.push_back(read_data_outputs);
      check("oe", bidir_data_lines_oe_n, narrow_mode ? 36'hf_fffc_0000 : '0);
    end
    pt = echo_clock_true;
    pc = echo_clock_comp;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test();
    end
  end
  // ====
  // main sequence
  initial
  begin
    rst = 1'b1;
    dll_off_n = 1'b1;
    narrow_mode = 1'b0;
    repeat (16) @(posedge core_clk);
    check("reset oe", bidir_data_lines_oe_n, '1);
    $display("test reset done");
    #1 rst = 1'b0;
    foreach (rows[i])
    begin
      mem_ctrl_model_i.op(1'b0, 1'b0, rows[i].a, rows[i].base, rows[i].base, '0, '0);
      mem_ctrl_model_i.op(1'b0, 1'b0, rows[i].a, rows[i].d0, rows[i].d1, rows[i].bw,
                          ~rows[i].bw);
      rd(rows[i].a, lanes(rows[i].base, rows[i].d0, rows[i].bw),
         lanes(rows[i].base, rows[i].d1, ~rows[i].bw), 5);
    end
    $display("test rows done");
    mem_ctrl_model_i.op(1'b1, 1'b0, rows[0].a, '0, '0, '0, '0);
    rd(rows[0].a, rows[0].d0, rows[0].base, 5);
    $display("test nop done");
    @(posedge core_clk) #1 dll_off_n = 1'b0;
    repeat (2) mem_ctrl_model_i.op(1'b1, 1'b0, '0, '0, '0, '0, '0);
    check("lock off", 36'(dll_locked), 36'h0);
    rd(rows[1].a, lanes(rows[1].base, rows[1].d0, rows[1].bw),
       lanes(rows[1].base, rows[1].d1, ~rows[1].bw), 2);
    @(posedge core_clk) #1 dll_off_n = 1'b1;
    repeat (2) mem_ctrl_model_i.op(1'b1, 1'b0, '0, '0, '0, '0, '0);
    check("lock early", 36'(dll_locked), 36'h0);
    repeat (4) mem_ctrl_model_i.op(1'b1, 1'b0, '0, '0, '0, '0, '0);
    check("lock", 36'(dll_locked), 36'h1);
    $display("test dll done");
    @(posedge core_clk) #1 narrow_mode = 1'b1;
    mem_ctrl_model_i.op(1'b0, 1'b0, 18'h0_0003, '1, '1, '0, '0);
    rd(18'h0_0003, '1, '1, 5);
    @(posedge core_clk) #1 narrow_mode = 1'b0;
    rd(18'h0_0003, 36'h0_0003_ffff, 36'h0_0003_ffff, 5);
    $display("test narrow done");
    end_of_test();
  end
endmodule
`default_nettype wire
